// File: verilog/scpns_top.v
// Serial configuration port with shadowed shaper and strobe settings.
// Assumes link pins are synchronous to i_clk and sampled on every i_clk cycle.
//
// Overview of operation
// R1 - Shaper enabled and configured per channel
// R2 - Enabled shaper adds fixed 0.6 dB loss
// R3 - Mode 000 selects narrow 22% band
// R4 - Mode 001 selects wide 33% band
// R5 - Six-bit tune code, 0.5% per step
// R6 - Narrow mode accepts codes 0 to 56
// R7 - Wide mode accepts codes 0 to 33
// R8 - Narrow band start, centre, edge formulas
// R9 - Wide band start, centre, edge formulas
// R10 - Register selects one-shot or every-strobe alignment
// R11 - Strobe synchronised into sample domain first
// R12 - Host drives strobe aligned to clock
// R13 - Bit 1 selects level or edge
// R14 - Bit 0 selects rising or falling edge
// R15 - Frame starts select low, clock rising
// R16 - Select may stream or pause between bytes
// R17 - Select high tristates pins, alternate functions
// R18 - Sixteen-bit instruction, length bits set bytes
// R19 - Bytes of eight, first bit read/write
// R20 - Read turns data pin to output
// R21 - MSB first default, LSB by setting
// R22 - Shadow writes apply on transfer, self-clears
// R23 - Channel select routes per-channel accesses
// R24 - Accepted strobe resets clock divider
// R25 - Instruction carries thirteen-bit register address
// R26 - Read data changes after falling clock
`timescale 1ns/1ps
`include "scpns_regs.vh"

module scpns_top (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_sclk,
    input  wire       i_select_n,
    input  wire       i_sdio,
    input  wire       i_strobe,
    output reg        o_sdio,
    output reg        o_sdio_oe,
    output reg        o_alt_func_en,
    output reg        o_div_reset,
    output reg  [1:0] o_shaper_en,
    output reg  [1:0] o_shaper_wide,
    output reg  [11:0] o_tune_code,
    output reg  [1:0] o_tune_bad,
    output reg  [17:0] o_band_start,
    output reg  [17:0] o_band_center,
    output reg  [17:0] o_band_stop
);

    localparam ST_INSTR = 2'h0;
    localparam ST_DATA  = 2'h1;

    reg  [1:0]  state_r;
    reg         sclk_d_r;
    reg         sel_d_r;
    reg  [15:0] instr_r;
    reg  [4:0]  bit_cnt_r;
    reg  [7:0]  shift_r;
    reg  [7:0]  rd_byte_r;
    reg         rd_r;
    reg  [2:0]  bytes_r;
    reg  [12:0] addr_r;
    reg         lsb_first_r;
    reg  [7:0]  chan_sel_r;
    reg  [7:0]  sync_sh_r;
    reg  [7:0]  sens_sh_r;
    reg  [7:0]  sync_act_r;
    reg  [7:0]  sens_act_r;
    reg  [7:0]  ctrl_sh_r  [0:1];
    reg  [7:0]  tune_sh_r  [0:1];
    reg  [7:0]  ctrl_act_r [0:1];
    reg  [7:0]  tune_act_r [0:1];
    reg         xfer_r;
    reg  [7:0]  rd_val;
    reg         arm_r;

    wire rise = i_sclk & ~sclk_d_r;
    wire fall = ~i_sclk & sclk_d_r;
    wire sel_rise = i_select_n & ~sel_d_r;
    wire in_bit = i_sdio;
    // Bit order: MSB first shifts left, LSB first shifts right
    wire [7:0] shifted = lsb_first_r ? {in_bit, shift_r[7:1]} : {shift_r[6:0], in_bit}; // R21
    wire [15:0] ins_next = lsb_first_r ? {in_bit, instr_r[15:1]} : {instr_r[14:0], in_bit};
    // LSB first: read/write and length bits still lead, the address arrives low bit first
    wire [15:0] ins_msb = lsb_first_r ?
        {ins_next[0], ins_next[1], ins_next[2],
         ins_next[15:3]} : ins_next; // R25
    wire [7:0] byte_msb = lsb_first_r ? shifted : shifted;
    wire byte_done = (bit_cnt_r[2:0] == 3'h7);
    wire chan_a = chan_sel_r[`SCPNS_CHAN_A_BIT];
    wire chan_b = chan_sel_r[`SCPNS_CHAN_B_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; both channels selected reads channel A
    always @* begin
        rd_val = 8'h00;
        case (addr_r)
            `SCPNS_ADDR_PORT_CFG:    rd_val = {6'h00, lsb_first_r, 1'b0};
            `SCPNS_ADDR_CHAN_SEL:    rd_val = chan_sel_r;
            `SCPNS_ADDR_SYNC_CTRL:   rd_val = sync_sh_r;
            `SCPNS_ADDR_STROBE_SENS: rd_val = sens_sh_r;
            `SCPNS_ADDR_SHAPER_CTRL: rd_val = chan_a ? ctrl_sh_r[0] : ctrl_sh_r[1]; // R23
            `SCPNS_ADDR_SHAPER_TUNE: rd_val = chan_a ? tune_sh_r[0] : tune_sh_r[1]; // R23
            default:                 rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Link framing and shadow register writes
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r      <= ST_INSTR;
            sclk_d_r     <= 1'b0;
            sel_d_r      <= 1'b1;
            instr_r      <= 16'h0000;
            bit_cnt_r    <= 5'h00;
            shift_r      <= 8'h00;
            rd_byte_r    <= 8'h00;
            rd_r         <= 1'b0;
            bytes_r      <= 3'h0;
            addr_r       <= 13'h0000;
            lsb_first_r  <= 1'b0;
            chan_sel_r   <= `SCPNS_RST_CHAN_SEL;
            sync_sh_r    <= `SCPNS_RST_ZERO;
            sens_sh_r    <= `SCPNS_RST_ZERO;
            ctrl_sh_r[0] <= `SCPNS_RST_ZERO;
            ctrl_sh_r[1] <= `SCPNS_RST_ZERO;
            tune_sh_r[0] <= `SCPNS_RST_ZERO;
            tune_sh_r[1] <= `SCPNS_RST_ZERO;
            xfer_r       <= 1'b0;
            o_sdio       <= 1'b0;
            o_sdio_oe    <= 1'b0;
            o_alt_func_en <= 1'b1;
        end else begin
            sclk_d_r      <= i_sclk;
            sel_d_r       <= i_select_n;
            xfer_r        <= 1'b0;
            o_alt_func_en <= i_select_n; // R17
            if (i_select_n) begin
                o_sdio_oe <= 1'b0; // R17
                // Streaming mode: select rising between bytes only pauses
                if (sel_rise && state_r == ST_INSTR && bit_cnt_r != 5'h00 && bit_cnt_r != 5'h08)
                    bit_cnt_r <= 5'h00; // R16
            end else if (rise) begin // R15
                case (state_r)
                    ST_INSTR: begin
                        instr_r   <= ins_next;
                        bit_cnt_r <= bit_cnt_r + 5'h01;
                        if (bit_cnt_r == 5'h0F) begin // R18
                            rd_r      <= ins_msb[15]; // R19
                            addr_r    <= ins_msb[12:0]; // R25
                            bytes_r   <= (ins_msb[14:13] == 2'h3) ? 3'h0 : {1'b0, ins_msb[14:13]} + 3'h1;
                            bit_cnt_r <= 5'h00;
                            state_r   <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        shift_r   <= shifted;
                        bit_cnt_r <= {2'h0, bit_cnt_r[2:0] + 3'h1};
                        if (byte_done) begin // R19
                            if (!rd_r) begin
                                case (addr_r)
                                    `SCPNS_ADDR_PORT_CFG:    lsb_first_r <= byte_msb[`SCPNS_PORT_CFG_LSB_BIT];
                                    `SCPNS_ADDR_CHAN_SEL:    chan_sel_r <= byte_msb;
                                    `SCPNS_ADDR_SYNC_CTRL:   sync_sh_r <= byte_msb;
                                    `SCPNS_ADDR_STROBE_SENS: sens_sh_r <= byte_msb;
                                    `SCPNS_ADDR_SHAPER_CTRL: begin // R1 R23
                                        if (chan_a) ctrl_sh_r[0] <= byte_msb;
                                        if (chan_b) ctrl_sh_r[1] <= byte_msb;
                                    end
                                    `SCPNS_ADDR_SHAPER_TUNE: begin // R5 R23
                                        if (chan_a) tune_sh_r[0] <= byte_msb;
                                        if (chan_b) tune_sh_r[1] <= byte_msb;
                                    end
                                    `SCPNS_ADDR_TRANSFER:    xfer_r <= byte_msb[`SCPNS_TRANSFER_BIT]; // R22
                                    default: ;
                                endcase
                            end
                            // Streaming walks addresses downward
                            addr_r <= addr_r - 13'h0001;
                            if (bytes_r == 3'h1) begin
                                state_r <= ST_INSTR;
                            end
                            if (bytes_r != 3'h0)
                                bytes_r <= bytes_r - 3'h1;
                        end
                    end
                    default: state_r <= ST_INSTR;
                endcase
            end else if (fall && state_r == ST_DATA && rd_r) begin // R26
                o_sdio_oe <= 1'b1; // R20
                if (bit_cnt_r[2:0] == 3'h0) begin
                    rd_byte_r <= rd_val;
                    o_sdio    <= lsb_first_r ? rd_val[0] : rd_val[7];
                end else begin
                    o_sdio <= lsb_first_r ? rd_byte_r[bit_cnt_r[2:0]] : rd_byte_r[3'h7 - bit_cnt_r[2:0]];
                end
            end else if (fall && state_r == ST_INSTR) begin
                o_sdio_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Active bank, loaded on transfer
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_act_r    <= `SCPNS_RST_ZERO;
            sens_act_r    <= `SCPNS_RST_ZERO;
            ctrl_act_r[0] <= `SCPNS_RST_ZERO;
            ctrl_act_r[1] <= `SCPNS_RST_ZERO;
            tune_act_r[0] <= `SCPNS_RST_ZERO;
            tune_act_r[1] <= `SCPNS_RST_ZERO;
            arm_r         <= 1'b0;
        end else begin
            arm_r <= xfer_r;
            if (xfer_r) begin // R22
                sync_act_r    <= sync_sh_r;
                sens_act_r    <= sens_sh_r;
                ctrl_act_r[0] <= ctrl_sh_r[0];
                ctrl_act_r[1] <= ctrl_sh_r[1];
                tune_act_r[0] <= tune_sh_r[0];
                tune_act_r[1] <= tune_sh_r[1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per-channel shaper settings
    wire [1:0]  en_w;
    wire [1:0]  wide_w;
    wire [11:0] tune_w;
    wire [1:0]  bad_w;
    wire [17:0] start_w;
    wire [17:0] center_w;
    wire [17:0] stop_w;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            scpns_shaper_chan u_chan (
                .i_clk             (i_clk),
                .i_rst_b           (i_rst_b),
                .i_ctrl            (ctrl_act_r[ch]),
                .i_tune            (tune_act_r[ch]),
                .o_enable          (en_w[ch]),
                .o_wide            (wide_w[ch]),
                .o_tune            (tune_w[ch*6 +: 6]),
                .o_tune_bad        (bad_w[ch]),
                .o_start_half_pct  (start_w[ch*9 +: 9]),
                .o_center_half_pct (center_w[ch*9 +: 9]),
                .o_stop_half_pct   (stop_w[ch*9 +: 9])
            );
        end
    endgenerate

    wire align_w;

    scpns_strobe_sync u_sync (
        .i_clk       (i_clk),
        .i_rst_b     (i_rst_b),
        .i_strobe    (i_strobe),
        .i_sync_en   (sync_act_r[`SCPNS_SYNC_EN_BIT]),
        .i_oneshot   (sync_act_r[`SCPNS_SYNC_ONESHOT_BIT]),
        .i_arm       (arm_r),
        .i_edge_mode (sens_act_r[`SCPNS_SENS_EDGE_BIT]),
        .i_falling   (sens_act_r[`SCPNS_SENS_FALL_BIT]),
        .o_align     (align_w)
    );

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_div_reset   <= 1'b0;
            o_shaper_en   <= 2'h0;
            o_shaper_wide <= 2'h0;
            o_tune_code   <= 12'h000;
            o_tune_bad    <= 2'h0;
            o_band_start  <= 18'h0_0000;
            o_band_center <= 18'h0_0000;
            o_band_stop   <= 18'h0_0000;
        end else begin
            o_div_reset   <= align_w; // R24
            o_shaper_en   <= en_w; // R1
            o_shaper_wide <= wide_w;
            o_tune_code   <= tune_w;
            o_tune_bad    <= bad_w;
            o_band_start  <= start_w;
            o_band_center <= center_w;
            o_band_stop   <= stop_w;
        end
    end

endmodule

// File: verilog/scpns_regs.vh
// Register offsets, field positions and reset values of the serial configuration port.
// Included by the top and shaper channel design files; definitions only.
`ifndef SCPNS_REGS_VH
`define SCPNS_REGS_VH

`define SCPNS_ADDR_PORT_CFG      13'h0000
`define SCPNS_ADDR_CHAN_SEL      13'h0005
`define SCPNS_ADDR_SYNC_CTRL     13'h003A
`define SCPNS_ADDR_SHAPER_CTRL   13'h003C
`define SCPNS_ADDR_SHAPER_TUNE   13'h003E
`define SCPNS_ADDR_STROBE_SENS   13'h0059
`define SCPNS_ADDR_TRANSFER      13'h00FF

`define SCPNS_PORT_CFG_LSB_BIT   1
`define SCPNS_CHAN_A_BIT         0
`define SCPNS_CHAN_B_BIT         1
`define SCPNS_SYNC_EN_BIT        1
`define SCPNS_SYNC_ONESHOT_BIT   2
`define SCPNS_SHAPER_EN_BIT      0
`define SCPNS_SHAPER_MODE_LSB    1
`define SCPNS_SHAPER_MODE_MSB    3
`define SCPNS_SENS_EDGE_BIT      1
`define SCPNS_SENS_FALL_BIT      0
`define SCPNS_TRANSFER_BIT       0

`define SCPNS_MODE_NARROW        3'h0
`define SCPNS_MODE_WIDE          3'h1
`define SCPNS_NARROW_TUNE_MAX    6'h38
`define SCPNS_WIDE_TUNE_MAX      6'h21

`define SCPNS_RST_PORT_CFG       8'h00
`define SCPNS_RST_CHAN_SEL       8'h03
`define SCPNS_RST_ZERO           8'h00

`endif

// File: verilog/scpns_strobe_sync.v
// Alignment strobe synchroniser and qualifier for the sample clock domain.
// Assumes the strobe pin is asynchronous; settings come from the active bank.
`timescale 1ns/1ps

module scpns_strobe_sync (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire       i_strobe,
    input  wire       i_sync_en,
    input  wire       i_oneshot,
    input  wire       i_arm,
    input  wire       i_edge_mode,
    input  wire       i_falling,
    output reg        o_align
);

    reg  meta_r;
    reg  sync_r;
    reg  prev_r;
    reg  armed_r;
    wire hit;

    always @(posedge i_clk or negedge i_rst_b) begin // R11
        if (!i_rst_b) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= i_strobe;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Level mode acts while high; edge mode on the chosen transition
    assign hit = i_edge_mode ? (i_falling ? (prev_r & ~sync_r) : (~prev_r & sync_r)) : sync_r; // R13 R14

    always @(posedge i_clk or negedge i_rst_b) begin // R10
        if (!i_rst_b) begin
            armed_r <= 1'b0;
            o_align <= 1'b0;
        end else begin
            o_align <= i_sync_en & hit & (~i_oneshot | armed_r); // R24
            if (i_arm)
                armed_r <= 1'b1;
            else if (i_sync_en & hit)
                armed_r <= 1'b0;
        end
    end

endmodule

// File: verilog/scpns_shaper_chan.v
// One channel's noise shaper settings: band edges and tune range flag as derived outputs.
// Assumes settings arrive from the active bank and are stable between transfers.
`timescale 1ns/1ps
`include "scpns_regs.vh"

module scpns_shaper_chan (
    input  wire       i_clk,
    input  wire       i_rst_b,
    input  wire [7:0] i_ctrl,
    input  wire [7:0] i_tune,
    output reg        o_enable,
    output reg        o_wide,
    output reg  [5:0] o_tune,
    output reg        o_tune_bad,
    output reg  [8:0] o_start_half_pct,
    output reg  [8:0] o_center_half_pct,
    output reg  [8:0] o_stop_half_pct
);

    wire [2:0] mode = i_ctrl[`SCPNS_SHAPER_MODE_MSB:`SCPNS_SHAPER_MODE_LSB];
    wire       wide = (mode == `SCPNS_MODE_WIDE);                        // R4
    wire [5:0] tc   = i_tune[5:0];                                       // R5
    wire [8:0] start = {3'h0, tc};                                       // R8 R9

    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_enable          <= 1'b0;
            o_wide            <= 1'b0;
            o_tune            <= 6'h00;
            o_tune_bad        <= 1'b0;
            o_start_half_pct  <= 9'h000;
            o_center_half_pct <= 9'h000;
            o_stop_half_pct   <= 9'h000;
        end else begin
            // Enabled shaper applies the fixed 0.6 dB output loss downstream
            o_enable          <= i_ctrl[`SCPNS_SHAPER_EN_BIT]; // R1 R2
            o_wide            <= wide; // R3
            o_tune            <= tc;
            o_tune_bad        <= wide ? (tc > `SCPNS_WIDE_TUNE_MAX) : (tc > `SCPNS_NARROW_TUNE_MAX); // R6 R7
            o_start_half_pct  <= start;
            o_center_half_pct <= start + (wide ? 9'h021 : 9'h016); // R8 R9
            o_stop_half_pct   <= start + (wide ? 9'h042 : 9'h02C); // R8 R9
        end
    end

endmodule

// File: test/scpns_host.sv
// Host model of the three-wire link: select, link clock and data pin.
// Assumes the link clock is i_clk divided by nine; it idles high outside frames.
`timescale 1ns/1ps

module scpns_host (
    input  wire i_clk,
    input  wire i_sdio,
    output reg  o_sclk,
    output reg  o_select_n,
    output reg  o_sdio
);
    reg       lsb_first;
    reg       pause;
    reg [1:0] len;

    initial begin
        lsb_first  = 1'b0;
        len        = 2'h0;
        pause      = 1'b0;
        o_sclk     = 1'b1;
        o_select_n = 1'b1;
        o_sdio     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One bit: data set with the fall, read bit taken just before the rise
    task automatic one_bit(input v, output s);
        begin
            @(posedge i_clk);
            o_sclk <= 1'b0;
            o_sdio <= v;
            repeat (4) @(posedge i_clk);
            s = i_sdio;
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
        end
    endtask

    task automatic frame(input rd, input [12:0] addr, input [7:0] wdat, output [7:0] rdat);
        reg [15:0] ins;
        reg        s;
        integer    k;
        begin
            ins = {rd, len, addr};
            @(posedge i_clk);
            o_select_n <= 1'b0;
            for (k = 0; k < 16; k = k + 1)
                one_bit((lsb_first && k > 2) ? addr[k - 3] : ins[15 - k], s);
            if (pause) begin
                o_select_n <= 1'b1;
                repeat (6) @(posedge i_clk);
                o_select_n <= 1'b0;
            end
            // Released line shows the inverse of the last value
            for (k = 0; k < 8 * (len + 1); k = k + 1) begin
                one_bit(rd ? ~o_sdio : wdat[lsb_first ? k % 8 : 7 - k % 8], s);
                rdat[lsb_first ? k % 8 : 7 - k % 8] = s;
            end
            repeat (4) @(posedge i_clk);
            o_select_n <= 1'b1;
            repeat (8) @(posedge i_clk);
        end
    endtask
endmodule

// File: test/scpns_top_properties.sv
// Checker of the serial configuration port on the top-level pins.
// Assumes the host idles the link clock high and keeps strobe edges apart.
`timescale 1ns/1ps

module scpns_top_chk (
    input logic        i_clk,
    input logic        i_rst_b,
    input logic        i_sclk,
    input logic        i_select_n,
    input logic        i_strobe,
    input logic        o_sdio,
    input logic        o_sdio_oe,
    input logic        o_alt_func_en,
    input logic        o_div_reset,
    input logic [1:0]  o_shaper_en,
    input logic [1:0]  o_shaper_wide,
    input logic [11:0] o_tune_code,
    input logic [1:0]  o_tune_bad,
    input logic [17:0] o_band_start,
    input logic [17:0] o_band_center,
    input logic [17:0] o_band_stop
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_set_a;
        ($stable(o_tune_code[5:0]) && $stable(o_shaper_wide[0]) && o_shaper_en[0]) [*3];
    endsequence
    sequence s_set_b;
        ($stable(o_tune_code[11:6]) && $stable(o_shaper_wide[1]) && o_shaper_en[1]) [*3];
    endsequence
    property p_chan_a;
        s_set_a |-> o_band_start[8:0] == o_tune_code[5:0]
            && o_band_center[8:0] == o_band_start[8:0] + (o_shaper_wide[0] ? 9'h021 : 9'h016)
            && o_band_stop[8:0] == o_band_start[8:0] + (o_shaper_wide[0] ? 9'h042 : 9'h02C)
            && o_tune_bad[0] == (o_tune_code[5:0] > (o_shaper_wide[0] ? 6'h21 : 6'h38));
    endproperty
    property p_chan_b;
        s_set_b |-> o_band_start[17:9] == o_tune_code[11:6]
            && o_band_center[17:9] == o_band_start[17:9] + (o_shaper_wide[1] ? 9'h021 : 9'h016)
            && o_band_stop[17:9] == o_band_start[17:9] + (o_shaper_wide[1] ? 9'h042 : 9'h02C)
            && o_tune_bad[1] == (o_tune_code[11:6] > (o_shaper_wide[1] ? 6'h21 : 6'h38));
    endproperty
    property p_alt_idle;
        i_select_n [*3] |-> o_alt_func_en && !o_sdio_oe;
    endproperty
    property p_oe_turn;
        $rose(o_sdio_oe) |-> !i_sclk && !i_select_n;
    endproperty
    property p_sdio_low;
        o_sdio_oe && !i_select_n && $changed(o_sdio) |-> !i_sclk;
    endproperty
    property p_sdio_hold;
        o_sdio_oe && !i_select_n && i_sclk |=> $stable(o_sdio);
    endproperty
    property p_strobe_sync;
        (!i_strobe) [*8] ##1 i_strobe |-> (!o_div_reset) [*2];
    endproperty
    property p_idle_hold;
        i_select_n [*8] |-> $stable(o_shaper_en) && $stable(o_tune_code);
    endproperty

    a_chan_a: assert property (p_chan_a) else $error("channel A band or flag wrong");
    a_chan_b: assert property (p_chan_b) else $error("channel B band or flag wrong");
    a_alt_idle: assert property (p_alt_idle) else $error("pins not released");
    a_oe_turn: assert property (p_oe_turn) else $error("data pin turned badly");
    a_sdio_low: assert property (p_sdio_low) else $error("read bit moved, clock high");
    a_sdio_hold: assert property (p_sdio_hold) else $error("read bit not held");
    a_strobe_sync: assert property (p_strobe_sync) else $error("strobe not synchronised");
    a_idle_hold: assert property (p_idle_hold) else $error("settings moved while idle");
endmodule

bind scpns_top scpns_top_chk i_scpns_top_chk (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(i_sclk), .i_select_n(i_select_n),
    .i_strobe(i_strobe), .o_sdio(o_sdio), .o_sdio_oe(o_sdio_oe), .o_alt_func_en(o_alt_func_en),
    .o_div_reset(o_div_reset), .o_shaper_en(o_shaper_en), .o_shaper_wide(o_shaper_wide),
    .o_tune_code(o_tune_code), .o_tune_bad(o_tune_bad), .o_band_start(o_band_start),
    .o_band_center(o_band_center), .o_band_stop(o_band_stop)
);

// File: test/testbench.sv
// Self-checking bench of the serial configuration port and its settings.
// Assumes the host model drives the link; the bench drives the strobe.
`timescale 1ns/1ps

module testbench;
    reg         clk;
    reg         rst_b;
    reg         strobe;
    wire        sclk, sel_n, host_sdio, dut_sdio, sdio_oe, alt_en, div_rst;
    wire [1:0]  sh_en, sh_wide, t_bad;
    wire [11:0] tune;
    wire [17:0] b_start, b_center, b_stop;
    wire        sdio_line;
    integer     err_total, total_checks, k, c, n, tn;
    reg  [7:0]  q;

    assign sdio_line = sdio_oe ? dut_sdio : host_sdio;

    scpns_top i_scpns_top (
        .i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_select_n(sel_n), .i_sdio(sdio_line),
        .i_strobe(strobe), .o_sdio(dut_sdio), .o_sdio_oe(sdio_oe), .o_alt_func_en(alt_en),
        .o_div_reset(div_rst), .o_shaper_en(sh_en), .o_shaper_wide(sh_wide), .o_tune_code(tune),
        .o_tune_bad(t_bad), .o_band_start(b_start), .o_band_center(b_center), .o_band_stop(b_stop)
    );
    scpns_host i_scpns_host (
        .i_clk(clk), .i_sdio(sdio_line), .o_sclk(sclk), .o_select_n(sel_n), .o_sdio(host_sdio)
    );

    ////////////////////////////////////////////////////////////////////////////
    task chk(input [17:0] seen, input [17:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input [12:0] a, input [7:0] d);
        begin
            i_scpns_host.frame(1'b0, a, d, q);
        end
    endtask

    task rd(input [12:0] a, input [7:0] e);
        begin
            i_scpns_host.frame(1'b1, a, 8'h00, q);
            chk(q, e);
        end
    endtask

    // Moves the strobe, then counts divider resets over twelve cycles
    task pulse_cnt(input v, output integer cnt);
        begin
            @(posedge clk);
            strobe <= v;
            cnt = 0;
            repeat (12) begin
                @(posedge clk);
                cnt = cnt + div_rst;
            end
        end
    endtask

    task wrap_up;
        begin
            if (err_total == 0 && total_checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (30000) @(posedge clk);
        err_total = err_total + 1;
        wrap_up;
    end

    initial begin
        err_total    = 0;
        total_checks = 0;
        rst_b        = 1'b0;
        strobe       = 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        chk({alt_en, sdio_oe, sh_en}, 4'b1000);
        rd(13'h0005, 8'h03);
        // Narrow then wide band, each at the last good code and one past it
        for (k = 0; k < 4; k = k + 1) begin
            c  = k / 2;
            tn = (c ? 6'h21 : 6'h38) + k % 2;
            wr(13'h0005, 8'h01 << c);
            wr(13'h003C, c ? 8'h03 : 8'h01);
            wr(13'h003E, tn[7:0]);
            if (k == 0)
                chk(sh_en, 2'b00);
            wr(13'h00FF, 8'h01);
            chk(sh_en[c], 1'b1);
            chk(sh_wide[c], c);
            chk(tune[6*c +: 6], tn);
            chk(t_bad[c], k % 2);
            chk(b_start[9*c +: 9], tn);
            chk(b_center[9*c +: 9], tn + (c ? 9'h021 : 9'h016));
            chk(b_stop[9*c +: 9], tn + (c ? 9'h042 : 9'h02C));
        end
        rd(13'h00FF, 8'h00);
        wr(13'h0013, 8'h5A);
        rd(13'h0013, 8'h00);
        wr(13'h0005, 8'h03);
        rd(13'h003E, 8'h39);
        i_scpns_host.pause = 1'b1;
        rd(13'h003C, 8'h01);
        i_scpns_host.pause = 1'b0;
        wr(13'h0000, 8'h02);
        i_scpns_host.lsb_first = 1'b1;
        rd(13'h003E, 8'h39);
        rd(13'h0000, 8'h02);
        wr(13'h0000, 8'h00);
        i_scpns_host.lsb_first = 1'b0;
        rd(13'h003C, 8'h01);
        // Edge mode, rising then falling, every strobe
        wr(13'h003A, 8'h02);
        wr(13'h0059, 8'h02);
        wr(13'h00FF, 8'h01);
        pulse_cnt(1'b1, n);
        chk(n, 1);
        pulse_cnt(1'b0, n);
        chk(n, 0);
        wr(13'h0059, 8'h03);
        wr(13'h00FF, 8'h01);
        pulse_cnt(1'b1, n);
        chk(n, 0);
        pulse_cnt(1'b0, n);
        chk(n, 1);
        // One-shot: only the first falling edge after the transfer counts
        wr(13'h003A, 8'h06);
        wr(13'h00FF, 8'h01);
        for (k = 0; k < 4; k = k + 1) begin
            pulse_cnt(~k[0], n);
            chk(n, k == 1);
        end
        wr(13'h003A, 8'h02);
        wr(13'h0059, 8'h00);
        wr(13'h00FF, 8'h01);
        pulse_cnt(1'b1, n);
        chk(n > 1, 1'b1);
        pulse_cnt(1'b0, n);
        // Two-byte write walks down from the unmapped 0x3D into shaper control
        i_scpns_host.len = 2'h1;
        wr(13'h003D, 8'h03);
        i_scpns_host.len = 2'h0;
        rd(13'h003C, 8'h03);
        wrap_up;
    end
endmodule
